// [shared/dcs_map.svh]
// Bit positions and reset values of the debug status and control register.
// Assumes inclusion by bare name from any design or package file.
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH

`define DCS_RX_FULL_BIT 30
`define DCS_TX_FULL_BIT 29
`define DCS_RX_LATCH_BIT 27
`define DCS_TX_LATCH_BIT 26
`define DCS_STICKY_BIT 25
`define DCS_DONE_LATCH_BIT 24
`define DCS_RSVD_HI_BIT 23
`define DCS_RSVD_LO_BIT 22
`define DCS_MODE_HI_BIT 21
`define DCS_MODE_LO_BIT 20
`define DCS_RUNCTL_CLR_STICKY_BIT 3
`define DCS_MODE_NONBLOCK 2'h0
`define DCS_MODE_STALL 2'h1
`define DCS_MODE_FAST 2'h2
`define DCS_MODE_RSVD 2'h3
`define DCS_MODE_RESET 2'h0
`define DCS_DATA_W 32

`endif

// [shared/dcs_pkg.sv]
// Types shared by the debug channel status logic.
// Assumes dcs_map.svh is on the include path.
`include "dcs_map.svh"

package dcs_pkg;

  typedef enum logic [1:0] {
    DCS_NONBLOCK = 2'h0,
    DCS_STALL = 2'h1,
    DCS_FAST = 2'h2,
    DCS_RSVD = 2'h3
  } dcs_mode_e;

  typedef enum logic [2:0] {
    DCS_TGT_NONE = 3'h0,
    DCS_TGT_STATUS = 3'h1,
    DCS_TGT_RX = 3'h2,
    DCS_TGT_TX = 3'h3,
    DCS_TGT_INSTR = 3'h4,
    DCS_TGT_RUNCTL = 3'h5
  } dcs_target_e;

  // One completed access from the external peripheral bus front end
  typedef struct packed {
    logic done;
    logic write;
    dcs_target_e target;
    logic [`DCS_DATA_W-1:0] wdata;
  } dcs_ext_acc_s;

  // Core-side events through the coprocessor debug path and pipeline
  typedef struct packed {
    logic rx_read;
    logic tx_write;
    logic status_read;
    logic retire;
    logic itr_start;
    logic itr_end;
  } dcs_core_evt_s;

endpackage

// [rtl/dcs_instr_done.sv]
// Instruction-complete flag and its latched copy.
// Assumes clear and event strobes are one-cycle pulses on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module dcs_instr_done (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic itr_start,
  input wire logic itr_end,
  input wire logic clear,
  input wire logic latch_now,
  output logic done_flag,
  output logic done_latched
);

  logic done_r;
  logic done_nxt;
  logic latch_r;
  logic latch_nxt;

  assign done_nxt = itr_end ? 1'b1 : ((clear || itr_start) ? 1'b0 : done_r);
  assign latch_nxt = clear ? 1'b0 : (latch_now ? done_r : latch_r);
  assign done_flag = done_r;
  assign done_latched = latch_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      done_r <= 1'b0;
      latch_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
      latch_r <= latch_nxt;
    end
  end

endmodule

`default_nettype wire

// [rtl/dcs_status.sv]
// Channel full flags, sticky advance, instruction-complete and access mode.
// Assumes access strobes come from same-clock bus and core logic.
`timescale 1ns/1ps
`default_nettype none
`include "dcs_map.svh"

module dcs_status (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_debug_state,
  input wire dcs_pkg::dcs_ext_acc_s ext_acc,
  input wire dcs_pkg::dcs_core_evt_s core_evt,
  output logic [`DCS_DATA_W-1:0] ext_rdata,
  output logic [`DCS_DATA_W-1:0] int_rdata,
  output dcs_pkg::dcs_mode_e access_mode,
  output logic rx_full_flag,
  output logic tx_full_flag,
  output logic instr_done_flag
);

  //////////////////////////////////////////////////////////////////////////////
  // Access decode

  // One completed external access of one direction and target
  function automatic logic ext_hit(
    input dcs_pkg::dcs_ext_acc_s acc,
    input logic is_write,
    input dcs_pkg::dcs_target_e tgt
  );
    return acc.done && (acc.write == is_write) && (acc.target == tgt);
  endfunction

  // Flag update where the set event wins a tie
  function automatic logic set_wins(
    input logic set_evt,
    input logic clr_evt,
    input logic cur
  );
    return set_evt ? 1'b1 : (clr_evt ? 1'b0 : cur);
  endfunction

  logic ext_rx_wr;
  logic ext_tx_rd;
  logic ext_itr_wr;
  logic ext_stat_wr;
  logic ext_stat_rd;
  logic ext_runctl_wr;
  logic mode_fast;
  logic done_clear;
  logic [1:0] mode_wr_val;
  logic mode_wr_ok;
  logic sticky_clr;
  dcs_pkg::dcs_mode_e mode_r;
  dcs_pkg::dcs_mode_e mode_nxt;

  assign ext_rx_wr = ext_hit(ext_acc, 1'b1, dcs_pkg::DCS_TGT_RX);
  assign ext_tx_rd = ext_hit(ext_acc, 1'b0, dcs_pkg::DCS_TGT_TX);
  assign ext_itr_wr = ext_hit(ext_acc, 1'b1, dcs_pkg::DCS_TGT_INSTR);
  assign ext_stat_wr = ext_hit(ext_acc, 1'b1, dcs_pkg::DCS_TGT_STATUS);
  assign ext_stat_rd = ext_hit(ext_acc, 1'b0, dcs_pkg::DCS_TGT_STATUS);
  assign ext_runctl_wr = ext_hit(ext_acc, 1'b1, dcs_pkg::DCS_TGT_RUNCTL);
  assign mode_wr_val = ext_acc.wdata[`DCS_MODE_HI_BIT:`DCS_MODE_LO_BIT];
  // Reserved code leaves the mode as it was
  assign mode_wr_ok = ext_stat_wr && (mode_wr_val != `DCS_MODE_RSVD);
  assign sticky_clr = ext_runctl_wr && ext_acc.wdata[`DCS_RUNCTL_CLR_STICKY_BIT];

  assign mode_fast = (mode_r == dcs_pkg::DCS_FAST);
  assign done_clear = (ext_itr_wr && !mode_fast) || (mode_fast && (ext_rx_wr || ext_tx_rd));

  //////////////////////////////////////////////////////////////////////////////
  // Flags

  logic rx_full_r;
  logic rx_full_nxt;
  logic tx_full_r;
  logic tx_full_nxt;
  logic sticky_r;
  logic sticky_nxt;

  assign rx_full_nxt = set_wins(ext_rx_wr, core_evt.rx_read, rx_full_r);
  assign tx_full_nxt = set_wins(core_evt.tx_write, ext_tx_rd, tx_full_r);
  // retire sets sticky
  // Retire beats a clear in the same cycle
  assign sticky_nxt = set_wins(core_evt.retire, sticky_clr, sticky_r);
  assign mode_nxt = mode_wr_ok ? dcs_pkg::dcs_mode_e'(mode_wr_val) : mode_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_full_r <= 1'b0;
      tx_full_r <= 1'b0;
      sticky_r <= 1'b0;
      mode_r <= dcs_pkg::DCS_NONBLOCK;
    end else begin
      rx_full_r <= rx_full_nxt;
      tx_full_r <= tx_full_nxt;
      sticky_r <= sticky_nxt;
      mode_r <= mode_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Instruction complete

  logic done_flag;
  logic done_latched;
  logic done_view_bit;

  assign done_view_bit = in_debug_state ? done_flag : done_latched;

  dcs_instr_done i_dcs_instr_done (
    .clk_sys(clk_sys),
    .rst(rst),
    .itr_start(core_evt.itr_start),
    .itr_end(core_evt.itr_end),
    .clear(done_clear),
    .latch_now(ext_stat_rd),
    .done_flag(done_flag),
    .done_latched(done_latched)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Read views

  logic [`DCS_DATA_W-1:0] ext_view;
  logic [`DCS_DATA_W-1:0] int_view;
  logic [`DCS_DATA_W-1:0] ext_rdata_r;
  logic [`DCS_DATA_W-1:0] int_rdata_r;

  always_comb begin
    ext_view = '0;
    ext_view[`DCS_RX_FULL_BIT] = rx_full_r;
    ext_view[`DCS_TX_FULL_BIT] = tx_full_r;
    ext_view[`DCS_RX_LATCH_BIT] = rx_full_r;
    ext_view[`DCS_TX_LATCH_BIT] = tx_full_r;
    ext_view[`DCS_STICKY_BIT] = sticky_r;
    ext_view[`DCS_DONE_LATCH_BIT] = done_view_bit;
    ext_view[`DCS_RSVD_HI_BIT] = 1'b0;
    ext_view[`DCS_RSVD_LO_BIT] = 1'b0;
    ext_view[`DCS_MODE_HI_BIT:`DCS_MODE_LO_BIT] = mode_r;
  end

  always_comb begin
    int_view = '0;
    int_view[`DCS_RX_FULL_BIT] = rx_full_r;
    int_view[`DCS_TX_FULL_BIT] = tx_full_r;
    int_view[`DCS_RX_LATCH_BIT] = 1'b0;
    int_view[`DCS_TX_LATCH_BIT] = 1'b0;
    int_view[`DCS_STICKY_BIT] = sticky_r;
    int_view[`DCS_DONE_LATCH_BIT] = 1'b0;
    int_view[`DCS_MODE_HI_BIT:`DCS_MODE_LO_BIT] = mode_r;
  end

  // Snapshot at the read edge keeps the returned word steady
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_rdata_r <= '0;
      int_rdata_r <= '0;
    end else begin
      if (ext_stat_rd) begin
        ext_rdata_r <= ext_view;
      end
      if (core_evt.status_read) begin
        int_rdata_r <= int_view;
      end
    end
  end

  assign ext_rdata = ext_rdata_r;
  assign int_rdata = int_rdata_r;
  assign access_mode = mode_r;
  assign rx_full_flag = rx_full_r;
  assign tx_full_flag = tx_full_r;
  assign instr_done_flag = done_flag;

endmodule

`default_nettype wire

// [testbench/dcs_status_assertions.sv]
// Port checks for dcs_status.
// Bound to every dcs_status instance.
`timescale 1ns/1ps
`default_nettype none
`include "dcs_map.svh"

module dcs_status_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_debug_state,
  input wire dcs_pkg::dcs_ext_acc_s ext_acc,
  input wire dcs_pkg::dcs_core_evt_s core_evt,
  input wire logic [`DCS_DATA_W-1:0] ext_rdata,
  input wire logic [`DCS_DATA_W-1:0] int_rdata,
  input wire dcs_pkg::dcs_mode_e access_mode,
  input wire logic rx_full_flag,
  input wire logic tx_full_flag,
  input wire logic instr_done_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic wr = ext_acc.done && ext_acc.write;
  wire logic rd = ext_acc.done && !ext_acc.write;
  wire logic rd_st = rd && ext_acc.target == 3'h1;
  wire logic wr_rx = wr && ext_acc.target == 3'h2;
  wire logic rd_tx = rd && ext_acc.target == 3'h3;
  wire logic [1:0] wm = ext_acc.wdata[21:20];
  // Done clear source depends on mode
  wire logic clr = access_mode == dcs_pkg::DCS_FAST ? wr_rx || rd_tx : wr && ext_acc.target == 3'h4;

  chk_rx_set: assert property (wr_rx |=> rx_full_flag) else $error("rx set");
  chk_rx_clear: assert property (core_evt.rx_read && !wr_rx |=> !rx_full_flag) else $error("rx clr");
  chk_tx_clear: assert property (rd_tx && !core_evt.tx_write |=> !tx_full_flag) else $error("tx clr");
  chk_adv_view: assert property (core_evt.retire ##1 !ext_acc.done ##1 rd_st |=> ext_rdata[25])
    else $error("adv");
  chk_done_view: assert property (rd_st && in_debug_state |=> ext_rdata[24] == $past(instr_done_flag))
    else $error("done view");
  chk_done_clear: assert property (clr && !core_evt.itr_end |=> !instr_done_flag) else $error("done clr");
  chk_mode_load: assert property (wr && ext_acc.target == 3'h1 && wm != 2'h3 |=> access_mode == $past(wm))
    else $error("mode");
  chk_rsvd_zero: assert property (ext_rdata[23:22] == 2'h0 && int_rdata[23:22] == 2'h0) else $error("rsvd");
endmodule

bind dcs_status dcs_status_assertions i_dcs_status_assertions (.clk_sys, .rst, .in_debug_state, .ext_acc,
  .core_evt, .ext_rdata, .int_rdata, .access_mode, .rx_full_flag, .tx_full_flag, .instr_done_flag);
`default_nettype wire

// [testbench/dcs_dbg_model.sv]
// Debugger model on the external bus.
// Drives one completed access at a time.
`timescale 1ns/1ps
`default_nettype none

module dcs_dbg_model (
  input wire logic clk_sys,
  output var dcs_pkg::dcs_ext_acc_s ext_acc
);
  initial ext_acc = '0;
  task automatic acc(input logic w, input logic [2:0] t, input logic [31:0] d);
    @(posedge clk_sys);
    #1 ext_acc = {1'b1, w, t, d};
    @(posedge clk_sys);
    // Released lines show noise
    #1 ext_acc = {1'b0, ~w, t, ~d};
  endtask
endmodule
`default_nettype wire

// [testbench/tb_dcs_status.sv]
// Self-checking bench for dcs_status.
// Uses the debugger model and bound checker.
`timescale 1ns/1ps
`default_nettype none

module tb_dcs_status;
  logic clk_sys;
  logic rst;
  logic in_debug_state;
  dcs_pkg::dcs_ext_acc_s ext_acc;
  dcs_pkg::dcs_core_evt_s core_evt;
  logic [31:0] ext_rdata;
  logic [31:0] int_rdata;
  dcs_pkg::dcs_mode_e access_mode;
  logic rx_full_flag;
  logic tx_full_flag;
  logic instr_done_flag;
  int fails;
  int cmp_count;
  logic [15:0] r;
  logic [1:0] m;

  dcs_status i_dcs_status (.clk_sys, .rst, .in_debug_state, .ext_acc, .core_evt, .ext_rdata, .int_rdata,
    .access_mode, .rx_full_flag, .tx_full_flag, .instr_done_flag);
  dcs_dbg_model i_dcs_dbg_model (.clk_sys, .ext_acc);

  ////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [1:0] exp_mode(input logic [1:0] p, input logic [1:0] q);
    return (q == 2'h3) ? p : q;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d errors %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic ev(input logic [5:0] e);
    @(posedge clk_sys);
    #1 core_evt = e;
    @(posedge clk_sys);
    #1 core_evt = '0;
  endtask
  task automatic acc(input logic w, input logic [2:0] t, input logic [31:0] d);
    i_dcs_dbg_model.acc(w, t, d);
  endtask
  // Status read, flag bits 30:24
  task automatic view(input logic [6:0] e);
    acc(1'b0, 3'h1, 32'h0);
    chk(ext_rdata[30:24], e);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    fails++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    in_debug_state = 1'b1;
    core_evt = '0;
    r = 16'h7C0C;
    m = 2'h2;
    repeat (3) @(posedge clk_sys);
    #1 rst = 1'b0;
    view(7'h00);
    acc(1'b1, 3'h2, {r, r});
    view(7'h48);
    ev(6'h20);
    view(7'h00);
    ev(6'h10);
    view(7'h24);
    acc(1'b0, 3'h3, 32'h0);
    view(7'h00);
    ev(6'h04);
    view(7'h02);
    acc(1'b1, 3'h5, 32'h8);
    view(7'h00);
    ev(6'h01);
    view(7'h01);
    ev(6'h02);
    view(7'h00);
    for (int k = 0; k < 3; k++) begin
      acc(1'b1, 3'h1, {10'h0, k[1:0], 20'h0});
      ev(6'h01);
      acc(1'b1, (k == 2) ? 3'h2 : 3'h4, 32'h0);
      acc(1'b0, 3'h1, 32'h0);
      chk(ext_rdata[24:20], {3'h0, k[1:0]});
    end
    ev(6'h01);
    acc(1'b1, 3'h4, 32'h0);
    view(7'h49);
    acc(1'b0, 3'h3, 32'h0);
    view(7'h48);
    repeat (40) begin
      r = lfsr(r);
      acc(1'b1, 3'h1, {r, r});
      m = exp_mode(m, r[5:4]);
      acc(1'b0, 3'h1, 32'h0);
      chk(ext_rdata[23:20], {2'h0, m});
      chk(access_mode, m);
    end
    // Mid-run reset back to defaults
    rst = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 rst = 1'b0;
    view(7'h00);
    chk(access_mode, 2'h0);
    ev(6'h01);
    view(7'h01);
    in_debug_state = 1'b0;
    view(7'h01);
    acc(1'b1, 3'h4, 32'h0);
    view(7'h00);
    in_debug_state = 1'b1;
    ev(6'h15);
    ev(6'h08);
    chk(int_rdata, 32'h2200_0000);
    view(7'h27);
    acc(1'b1, 3'h1, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
